//--- accel_irq_wake_routing.sv
`timescale 1ns/1ns
// Summary of operation
// R1 - Gate bit 0: flush FIFO on every wake/sleep change.
// R2 - Gate bit 1: keep FIFO on change, drop new samples until emptied.
// R3 - Gate set and FIFO unemptied at next sample raises hold error.
// R4 - Hold error clears once host empties the FIFO.
// R5 - Five wake-select bits let their function's interrupt wake sleep.
// R6 - Polarity bit: 0 asserts pins low, 1 asserts high; resets 0.
// R7 - Drive-type bit: 0 push-pull, 1 open drain; resets 0.
// R8 - Eight enable bits pass source flags to the controller; reset 0.
// R9 - Routing bit 0 sends source to pin b, 1 to pin a.
// R10 - Host reads source register to find which sources fired.
// R11 - Offset trims are signed bytes of 3.906 mg per count.
// R12 - X, Y, Z trims at three consecutive addresses, RW, reset zero.
// R13 - Enabled auto-sleep interrupt fires on each active/sleep change.
// R14 - FIFO keeps device awake but never wakes it.
// R15 - Pin active while any enabled routed source is pending.
module accel_irq_wake_routing #(
    parameter int NSRC = airq_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Detection events, bit order as enable register
    input wire logic [NSRC-1:0] src_event_i,
    input wire logic [NSRC-1:0] src_ack_i,
    // System mode and FIFO
    input wire logic sleeping_i,
    input wire logic sample_strobe_i,
    input wire logic fifo_empty_i,
    input wire logic fifo_active_i,
    output logic fifo_flush_o,
    output logic sample_accept_o,
    output logic wake_req_o,
    output logic keep_awake_o,
    // Offset trims
    output logic [7:0] x_offset_trim_o,
    output logic [7:0] y_offset_trim_o,
    output logic [7:0] z_offset_trim_o,
    // Interrupt pads
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe_o,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe_o
);
    logic [7:0] wake_ctl_q;
    logic [NSRC-1:0] enable_q;
    logic [NSRC-1:0] route_q;
    logic [7:0] trim_q [3];
    logic [NSRC-1:0] pend_q;
    logic sleep_q;
    logic hold_err_q;
    airq_pkg::airq_gate_t gate_q;
    logic mode_change;
    logic gate_on;
    logic [NSRC-1:0] live;
    logic [NSRC-1:0] set_ev;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return reg_wr_i && (a == b);
    endfunction

    assign gate_on = wake_ctl_q[airq_pkg::BIT_GATE];
    assign mode_change = sleeping_i != sleep_q;

    // Registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_ctl_q <= airq_pkg::RST_BYTE; // R6 R7
            enable_q <= '0; // R8
            route_q <= '0; // R9
        end else begin
            if (hit(reg_addr_i, airq_pkg::ADDR_WAKE_CTRL)) begin
                wake_ctl_q <= reg_wdata_i;
            end
            if (hit(reg_addr_i, airq_pkg::ADDR_ENABLE)) begin
                enable_q <= reg_wdata_i[NSRC-1:0]; // R8
            end
            if (hit(reg_addr_i, airq_pkg::ADDR_ROUTING)) begin
                route_q <= reg_wdata_i[NSRC-1:0]; // R9
            end
        end
    end

    // Offset trims, passed on as signed counts
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_trim
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    trim_q[g] <= airq_pkg::RST_BYTE; // R12
                end else if (hit(reg_addr_i,
                        8'(airq_pkg::ADDR_OFF_X + 8'(g)))) begin
                    trim_q[g] <= reg_wdata_i; // R11 R12
                end
            end
        end
    endgenerate
    assign x_offset_trim_o = trim_q[0];
    assign y_offset_trim_o = trim_q[1];
    assign z_offset_trim_o = trim_q[2];

    // Mode tracking
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleeping_i;
        end
    end

    // Auto-sleep source is generated here from the mode change
    always_comb begin
        set_ev = src_event_i;
        set_ev[airq_pkg::SRC_AUTOSLEEP] = mode_change; // R13
    end

    // Pending flags; a new event wins over an acknowledge
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~src_ack_i) | (set_ev & enable_q); // R8 R13
        end
    end

    assign live = pend_q & enable_q;

    // Wake from sleep only through selected detection functions
    always_comb begin
        logic [4:0] wk;
        wk = wake_ctl_q[airq_pkg::BIT_WAKE_HI:airq_pkg::BIT_WAKE_LO];
        // Sources 5..1: transient, orientation, tap, motion one, two
        wake_req_o = sleeping_i && |(wk & src_event_i[5:1]); // R5 R14
    end
    assign keep_awake_o = fifo_active_i; // R14

    // FIFO gate across mode changes
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_q <= airq_pkg::AIRQ_IDLE;
        end else begin
            unique case (gate_q)
                airq_pkg::AIRQ_IDLE: begin
                    if (mode_change && gate_on && !fifo_empty_i) begin
                        gate_q <= airq_pkg::AIRQ_GATED; // R2
                    end
                end
                airq_pkg::AIRQ_GATED: begin
                    if (fifo_empty_i) begin
                        gate_q <= airq_pkg::AIRQ_IDLE; // R4
                    end else if (sample_strobe_i) begin
                        gate_q <= airq_pkg::AIRQ_ERR; // R3
                    end
                end
                airq_pkg::AIRQ_ERR: begin
                    if (fifo_empty_i) begin
                        gate_q <= airq_pkg::AIRQ_IDLE; // R4
                    end
                end
                default: gate_q <= airq_pkg::AIRQ_IDLE;
            endcase
        end
    end
    assign hold_err_q = gate_q == airq_pkg::AIRQ_ERR; // R3

    assign fifo_flush_o = mode_change && !gate_on; // R1
    assign sample_accept_o = sample_strobe_i &&
        gate_q == airq_pkg::AIRQ_IDLE; // R2

    // Read mux, registered
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= airq_pkg::RST_BYTE;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                airq_pkg::ADDR_SYS_MODE:
                    reg_rdata_o <= {1'b0, hold_err_q, 5'h00, sleep_q}; // R3
                airq_pkg::ADDR_IRQ_SOURCE: reg_rdata_o <= 8'(live); // R10
                airq_pkg::ADDR_WAKE_CTRL: reg_rdata_o <= wake_ctl_q;
                airq_pkg::ADDR_ENABLE: reg_rdata_o <= 8'(enable_q);
                airq_pkg::ADDR_ROUTING: reg_rdata_o <= 8'(route_q);
                airq_pkg::ADDR_OFF_X: reg_rdata_o <= trim_q[0];
                airq_pkg::ADDR_OFF_Y: reg_rdata_o <= trim_q[1];
                airq_pkg::ADDR_OFF_Z: reg_rdata_o <= trim_q[2];
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Pins
    airq_pin_drv u_pin_a (
        .active_i(|(live & route_q)), // R9 R15
        .polarity_i(wake_ctl_q[airq_pkg::BIT_POL]),
        .open_drain_i(wake_ctl_q[airq_pkg::BIT_DRIVE]),
        .pad_o(irq_pin_a_o),
        .pad_oe_o(irq_pin_a_oe_o)
    );
    airq_pin_drv u_pin_b (
        .active_i(|(live & ~route_q)), // R9 R15
        .polarity_i(wake_ctl_q[airq_pkg::BIT_POL]),
        .open_drain_i(wake_ctl_q[airq_pkg::BIT_DRIVE]),
        .pad_o(irq_pin_b_o),
        .pad_oe_o(irq_pin_b_oe_o)
    );

    gate_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        gate_q == airq_pkg::AIRQ_GATED && !fifo_empty_i && sample_strobe_i
        |=> hold_err_q) else $error("hold error not raised"); // R3
    err_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fifo_empty_i |=> !hold_err_q) else $error("hold error kept"); // R4
    flush_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $changed(sleeping_i) && !gate_on |-> fifo_flush_o)
        else $error("no flush on mode change"); // R1
    drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        gate_q != airq_pkg::AIRQ_IDLE |-> !sample_accept_o)
        else $error("sample taken while gated"); // R2
    aslp_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        mode_change && enable_q[7] |=> pend_q[7])
        else $error("auto-sleep flag missing"); // R13
    wake_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wake_req_o |-> sleeping_i && |src_event_i[5:1])
        else $error("bad wake"); // R5 R14
    pin_b_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        |(live & ~route_q) |-> irq_pin_b_o == wake_ctl_q[1])
        else $error("pin b not active"); // R6 R9 R15
    pin_a_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(|(live & route_q)) && !wake_ctl_q[0]
        |-> irq_pin_a_o == !wake_ctl_q[1] && irq_pin_a_oe_o)
        else $error("pin a not idle"); // R7 R15
    pend_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        src_event_i[0] && enable_q[0] |=> pend_q[0])
        else $error("enabled event not latched"); // R8
    cov_gate: cover property (@(posedge ref_clk_i) hold_err_q);
    cov_pin_a: cover property (@(posedge ref_clk_i) |(live & route_q));
    cov_wake: cover property (@(posedge ref_clk_i) wake_req_o);
endmodule

//--- airq_pkg.sv
package airq_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_SYS_MODE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h15;
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'h3A;
    localparam logic [7:0] ADDR_ENABLE = 8'h3B;
    localparam logic [7:0] ADDR_ROUTING = 8'h3C;
    localparam logic [7:0] ADDR_OFF_X = 8'h3D;
    localparam logic [7:0] ADDR_OFF_Y = 8'h3E;
    localparam logic [7:0] ADDR_OFF_Z = 8'h3F;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Control field positions
    localparam int BIT_GATE = 7;
    localparam int BIT_WAKE_HI = 6;
    localparam int BIT_WAKE_LO = 2;
    localparam int BIT_POL = 1;
    localparam int BIT_DRIVE = 0;
    localparam int BIT_HOLD_ERR = 6;
    // Source bit positions
    localparam int SRC_AUTOSLEEP = 7;
    localparam int SRC_FIFO = 6;
    localparam int SRC_SAMPLE_READY = 0;
    localparam int NUM_SRC = 8;
    localparam int NUM_WAKE = 5;
    // Offset weight, micro-g per count
    localparam int OFFSET_UG_PER_COUNT = 3906;
    typedef enum logic [1:0] {
        AIRQ_IDLE = 2'b00,
        AIRQ_GATED = 2'b01,
        AIRQ_ERR = 2'b11
    } airq_gate_t;
endpackage

//--- airq_pin_drv.sv
`timescale 1ns/1ns
module airq_pin_drv (
    // Request and pin control
    input wire logic active_i,
    input wire logic polarity_i,
    input wire logic open_drain_i,
    // Pad
    output logic pad_o,
    output logic pad_oe_o
);
    always_comb begin
        // Polarity applied to the asserted level
        pad_o = active_i ? polarity_i : ~polarity_i; // R6
        // Open drain only drives the asserted level, for either polarity
        if (open_drain_i) begin // R7
            pad_oe_o = active_i;
        end else begin
            pad_oe_o = 1'b1;
        end
    end
endmodule

//--- airq_host_model.sv
`timescale 1ns/1ns
module airq_host_model (
    // Device pads
    input wire logic pad_a_i,
    input wire logic oe_a_i,
    input wire logic pad_b_i,
    input wire logic oe_b_i,
    // Lines as the host sees them
    output logic line_a_o,
    output logic line_b_o
);
    // Board pull-up: a released open-drain line reads high
    assign line_a_o = oe_a_i ? pad_a_i : 1'b1;
    assign line_b_o = oe_b_i ? pad_b_i : 1'b1;
endmodule

//--- accel_irq_wake_routing_tb_top.sv
`timescale 1ns/1ns
module accel_irq_wake_routing_tb_top;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic slp = 1'b0, smp = 1'b0, emp = 1'b1, act = 1'b0, pol, od;
    logic [7:0] ad = 8'h00, wd = 8'h00, ev = 8'h00, ack = 8'h00, en, rt;
    logic [7:0] rdat, xo, yo, zo, v, rb;
    logic flush, acc, wake, keep, pa, pa_oe, pb, pb_oe, la, lb;
    int n_mismatch = 0, cmp_count = 0, seed = 93, k;
    accel_irq_wake_routing uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(ad), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .src_event_i(ev),
        .src_ack_i(ack), .sleeping_i(slp), .sample_strobe_i(smp),
        .fifo_empty_i(emp), .fifo_active_i(act), .fifo_flush_o(flush),
        .sample_accept_o(acc), .wake_req_o(wake), .keep_awake_o(keep),
        .x_offset_trim_o(xo), .y_offset_trim_o(yo), .z_offset_trim_o(zo),
        .irq_pin_a_o(pa), .irq_pin_a_oe_o(pa_oe), .irq_pin_b_o(pb),
        .irq_pin_b_oe_o(pb_oe));
    airq_host_model host (.pad_a_i(pa), .oe_a_i(pa_oe), .pad_b_i(pb),
        .oe_b_i(pb_oe), .line_a_o(la), .line_b_o(lb));
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        ad = a;
        wd = d;
        wr_s = 1'b1;
        @(negedge ref_clk_i);
        wr_s = 1'b0;
    endtask
    // Read data stands until the next read, so sample a cycle late
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        ad = a;
        rd_s = 1'b1;
        @(negedge ref_clk_i);
        rd_s = 1'b0;
        @(negedge ref_clk_i);
        d = rdat;
    endtask
    task automatic pulse(input logic [7:0] e, input logic [7:0] c);
        @(negedge ref_clk_i);
        ev = e;
        ack = c;
        @(negedge ref_clk_i);
        ev = 8'h00;
        ack = 8'h00;
        @(negedge ref_clk_i);
    endtask
    function automatic logic lvl(logic on, logic p, logic o);
        return on ? p : (o ? 1'b1 : !p);
    endfunction
    task automatic pins(input logic ea, input logic eb);
        chk("line a", la, lvl(ea, pol, od));
        chk("line b", lb, lvl(eb, pol, od));
        chk("oe a", pa_oe, od ? ea : 1'b1);
        chk("oe b", pb_oe, od ? eb : 1'b1);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (10) @(negedge ref_clk_i);
        rst_i = 1'b0;
        pol = 1'b0;
        od = 1'b0;
        pins(1'b0, 1'b0);
        for (k = 0; k < 9; k++) begin
            rd(8'h14 + ((k < 2) ? k : k + 36), v);
            chk("reset value", v, (k == 8) ? 8'h00 : 8'h00);
        end
        $display("done reset");
        for (k = 0; k < 3; k++) begin
            v = $random(seed);
            wr(airq_pkg::ADDR_OFF_X + k, v);
            rd(airq_pkg::ADDR_OFF_X + k, rb);
            chk("trim read", rb, v);
            chk("trim", (k == 0) ? xo : ((k == 1) ? yo : zo), v);
        end
        wr(airq_pkg::ADDR_IRQ_SOURCE, 8'hFF);
        rd(airq_pkg::ADDR_IRQ_SOURCE, v);
        chk("read only", v, 8'h00);
        $display("done trims");
        for (k = 0; k < 21; k++) begin
            {pol, od} = $random(seed);
            en = $random(seed);
            rt = $random(seed);
            wr(airq_pkg::ADDR_WAKE_CTRL, {6'h00, pol, od});
            wr(airq_pkg::ADDR_ENABLE, en);
            wr(airq_pkg::ADDR_ROUTING, rt);
            pulse(8'h01 << (k % 7), 8'h00);
            pins(en[k % 7] && rt[k % 7], en[k % 7] && !rt[k % 7]);
            rd(airq_pkg::ADDR_IRQ_SOURCE, v);
            chk("source", v, en & (8'h01 << (k % 7)));
            rd(airq_pkg::ADDR_ENABLE, v);
            chk("enable", v, en);
            rd(airq_pkg::ADDR_ROUTING, v);
            chk("routing", v, rt);
            pulse(8'h00, 8'hFF);
            pins(1'b0, 1'b0);
        end
        $display("done routing");
        wr(airq_pkg::ADDR_ROUTING, 8'h80);
        wr(airq_pkg::ADDR_ENABLE, 8'h80);
        for (k = 0; k < 2; k++) begin
            @(negedge ref_clk_i);
            slp = !slp;
            pulse(8'h00, 8'h00);
            pins(1'b1, 1'b0);
            pulse(8'h00, 8'hFF);
        end
        $display("done autosleep");
        // Wake requests only count while the system sleeps
        slp = 1'b1;
        for (k = 1; k < 7; k++) begin
            v = $random(seed);
            wr(airq_pkg::ADDR_WAKE_CTRL, {1'b0, v[4:0], 2'b00});
            @(negedge ref_clk_i);
            ev = 8'h01 << k;
            act = v[5];
            #20;
            chk("wake", wake, (k < 6) && v[k - 1]);
            chk("keep awake", keep, v[5]);
            pulse(8'h00, 8'hFF);
        end
        $display("done wake");
        wr(airq_pkg::ADDR_WAKE_CTRL, 8'h00);
        @(negedge ref_clk_i);
        slp = !slp;
        #20;
        chk("flush", flush, 1'b1);
        emp = 1'b0;
        wr(airq_pkg::ADDR_WAKE_CTRL, 8'h80);
        slp = !slp;
        #20;
        chk("no flush", flush, 1'b0);
        @(negedge ref_clk_i);
        smp = 1'b1;
        #20;
        chk("dropped", acc, 1'b0);
        @(negedge ref_clk_i);
        smp = 1'b0;
        for (k = 0; k < 3; k++) begin
            emp = (k == 2);
            rd(airq_pkg::ADDR_SYS_MODE, v);
            chk("hold error", v[6], k < 2);
        end
        smp = 1'b1;
        #20;
        chk("accepted", acc, 1'b1);
        $display("done gate");
        wrap_up();
    end
endmodule
